// *** dv/mcr_core_model.sv ***
// Core-side model issuing coprocessor register transfers
`timescale 1ns/1ps
`default_nettype none
module mcr_core_model import mcr_pkg::*; (
  input wire logic ref_clk_i,
  output var mcr_req_t req_o,
  input wire logic done_i,
  input wire logic und_trap_i
);
  initial req_o = '0;

  // One transfer: request for one cycle, answer read one cycle later
  task automatic xfer(input logic rd, input logic pv, input logic [3:0] cp, input logic [3:0] rn,
                      input logic [31:0] wd, output logic [1:0] ans);
    mcr_req_t r;
    r = '{valid: 1'b1, is_read: rd, privileged: pv, coproc: cp, regnum: rn, wdata: wd};
    @(posedge ref_clk_i);
    req_o <= r;
    @(posedge ref_clk_i);
    // Released fields show the inverse, never a stale copy
    req_o <= ~r;
    #1;
    ans = {done_i, und_trap_i};
  endtask : xfer
endmodule : mcr_core_model
`default_nettype wire

// *** dv/mcr_regbank_bench.sv ***
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module mcr_regbank_bench;
  import mcr_pkg::*;
  localparam logic [1:0] A_OK = 2'b10;
  localparam logic [1:0] A_TRAP = 2'b01;
  localparam logic [1:0] A_NONE = 2'b00;
  logic ref_clk_i;
  logic resetn_i;
  mcr_req_t req;
  logic [31:0] fault_status_i;
  logic [31:0] fault_addr_i;
  logic done_o, und_trap_o, tlb_flush_o, tlb_purge_o, cache_flush_o;
  logic [31:0] rdata_o, ttb_o, dac_o, purge_addr_o;
  mcr_cfg_t cfg_o;
  int checks = 0;
  int miscompares = 0;
  int cycles = 0;

  mcr_regbank mcr_regbank_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req),
    .fault_status_i(fault_status_i), .fault_addr_i(fault_addr_i), .done_o(done_o),
    .und_trap_o(und_trap_o), .rdata_o(rdata_o), .cfg_o(cfg_o), .ttb_o(ttb_o), .dac_o(dac_o),
    .tlb_flush_o(tlb_flush_o), .tlb_purge_o(tlb_purge_o), .purge_addr_o(purge_addr_o),
    .cache_flush_o(cache_flush_o));
  mcr_core_model mcr_core_model_i (.ref_clk_i(ref_clk_i), .req_o(req), .done_i(done_o),
    .und_trap_i(und_trap_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic op(input logic rd, input logic pv, input logic [3:0] cp, input logic [3:0] rn,
                    input logic [31:0] wd, input logic [1:0] exp);
    logic [1:0] ans;
    mcr_core_model_i.xfer(rd, pv, cp, rn, wd, ans);
    chk({30'h0, ans}, {30'h0, exp});
  endtask : op

  task automatic close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic do_reset;
    @(posedge ref_clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk({21'h0, cfg_o, done_o, und_trap_o, tlb_flush_o, tlb_purge_o, cache_flush_o}, 32'h0);
    @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask : do_reset

  // Hang guard, far above the expected hundred or so cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      close_out;
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetn_i = 1'b0;
    fault_status_i = 32'h0000_00a5;
    fault_addr_i = 32'hc0de_0040;
    do_reset;
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_CTRL, 32'h1 << i, A_OK);
      chk({26'h0, cfg_o}, 32'h20 >> i);
    end
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_CTRL, 32'hffff_ffc0, A_OK);
    chk({26'h0, cfg_o}, 32'h0);
    op(1'b1, 1'b1, MCR_COPROC_NUM, MCR_REG_CTRL, 32'h0, A_NONE);
    $display("test control done");
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_TTB, 32'habcd_4000, A_OK);
    chk(ttb_o, 32'habcd_4000);
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_DAC, 32'h5555_aaaa, A_OK);
    chk(dac_o, 32'h5555_aaaa);
    op(1'b1, 1'b1, MCR_COPROC_NUM, MCR_REG_ID, 32'h0, A_OK);
    chk(rdata_o, MCR_ID_DEFAULT);
    op(1'b1, 1'b1, MCR_COPROC_NUM, MCR_REG_FSR, 32'h0, A_OK);
    chk(rdata_o, 32'h0000_00a5);
    op(1'b1, 1'b1, MCR_COPROC_NUM, MCR_REG_FAR, 32'h0, A_OK);
    chk(rdata_o, 32'hc0de_0040);
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_FSR, 32'h0, A_OK);
    chk({31'h0, tlb_flush_o}, 32'h1);
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_FAR, 32'h0012_3000, A_OK);
    chk({tlb_purge_o, purge_addr_o[30:0]}, 32'h8012_3000);
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_CFLUSH, 32'h0, A_OK);
    chk({31'h0, cache_flush_o}, 32'h1);
    $display("test decode done");
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_ID, 32'h0, A_NONE);
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_RSV4, 32'h0, A_NONE);
    for (int i = 1; i < 8; i++) begin
      if (i < 5 || i == 7) op(1'b1, 1'b1, MCR_COPROC_NUM, i[3:0], 32'h0, A_NONE);
    end
    chk(rdata_o, 32'hc0de_0040);
    op(1'b0, 1'b0, MCR_COPROC_NUM, MCR_REG_CTRL, 32'h3f, A_TRAP);
    op(1'b1, 1'b0, MCR_COPROC_NUM, MCR_REG_ID, 32'h0, A_TRAP);
    for (int i = 8; i < 16; i++) begin
      op(1'b1, 1'b1, MCR_COPROC_NUM, i[3:0], 32'h0, A_TRAP);
      op(1'b0, 1'b1, MCR_COPROC_NUM, i[3:0], 32'h3f, A_TRAP);
    end
    op(1'b0, 1'b1, 4'he, MCR_REG_CTRL, 32'h3f, A_NONE);
    chk({26'h0, cfg_o}, 32'h0);
    $display("test refusals done");
    op(1'b0, 1'b1, MCR_COPROC_NUM, MCR_REG_CTRL, 32'h3f, A_OK);
    chk({26'h0, cfg_o}, 32'h3f);
    do_reset;
    $display("test mid-run reset done");
    close_out;
  end
endmodule : mcr_regbank_bench
`default_nettype wire

// *** verilog/mcr_pkg.sv ***
// Package: constants and types for the system control register bank
// ----------------------------------------------------------------
// Summary of operation
// - Bank reached only by coprocessor 15 register transfers in privileged mode.
// - Any access from user mode takes the undefined instruction trap instead.
// - Invalid registers 0-7: no access performed and no trap raised.
// - Any access to register numbers 8 to 15 takes the undefined trap.
// - Reads: 0 identity, 5 fault status, 6 fault address; others reserved.
// - Register 2 is write-only, holding the first-level page table base.
// - Control register write-only; bits 31 down to 10 are not stored.
// - Reset clears every control bit.
// - Control bit 0 enables the memory management unit.
// - Control bit 2 enables the unified instruction and data cache.
// - Control bit 3 enables the write buffer.
// - Control bit 4 selects 32-bit program space, else 26-bit.
// ----------------------------------------------------------------
package mcr_pkg;
  localparam logic [3:0] MCR_COPROC_NUM = 4'hf;
  localparam logic [3:0] MCR_REG_ID = 4'h0;
  localparam logic [3:0] MCR_REG_CTRL = 4'h1;
  localparam logic [3:0] MCR_REG_TTB = 4'h2;
  localparam logic [3:0] MCR_REG_DAC = 4'h3;
  localparam logic [3:0] MCR_REG_RSV4 = 4'h4;
  localparam logic [3:0] MCR_REG_FSR = 4'h5;
  localparam logic [3:0] MCR_REG_FAR = 4'h6;
  localparam logic [3:0] MCR_REG_CFLUSH = 4'h7;
  localparam int MCR_CTRL_W = 10;
  localparam int MCR_BIT_MMU = 0;
  localparam int MCR_BIT_ALIGN = 1;
  localparam int MCR_BIT_CACHE = 2;
  localparam int MCR_BIT_WBUF = 3;
  localparam int MCR_BIT_PROG32 = 4;
  localparam int MCR_BIT_DATA32 = 5;
  localparam logic [9:0] MCR_CTRL_RST = 10'h000;
  localparam logic [31:0] MCR_WORD_RST = 32'h0000_0000;
  // Arbitrary neutral identity value
  localparam logic [31:0] MCR_ID_DEFAULT = 32'h1234_0000;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic privileged;
    logic [3:0] coproc;
    logic [3:0] regnum;
    logic [31:0] wdata;
  } mcr_req_t;

  typedef struct packed {
    logic mmu_en;
    logic align_en;
    logic cache_en;
    logic wbuf_en;
    logic prog32;
    logic data32;
  } mcr_cfg_t;

  typedef enum logic [2:0] {
    MCR_RESP_NONE = 3'b001,
    MCR_RESP_OK = 3'b010,
    MCR_RESP_UND = 3'b100
  } mcr_resp_t;
endpackage : mcr_pkg

// *** verilog/mcr_regbank.sv ***
// File: system control register bank reached by coprocessor register transfers
`timescale 1ns/1ps
`default_nettype none
module mcr_regbank import mcr_pkg::*; #(
  parameter logic [31:0] ID_VALUE = MCR_ID_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire mcr_req_t req_i,
  input wire logic [31:0] fault_status_i,
  input wire logic [31:0] fault_addr_i,
  output logic done_o,
  output logic und_trap_o,
  output logic [31:0] rdata_o,
  output mcr_cfg_t cfg_o,
  output logic [31:0] ttb_o,
  output logic [31:0] dac_o,
  output logic tlb_flush_o,
  output logic tlb_purge_o,
  output logic [31:0] purge_addr_o,
  output logic cache_flush_o
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n_r;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic rd_valid(input logic [3:0] r);
    rd_valid = (r == MCR_REG_ID) || (r == MCR_REG_FSR) || (r == MCR_REG_FAR);
  endfunction : rd_valid

  function automatic logic wr_valid(input logic [3:0] r);
    wr_valid = (r != MCR_REG_ID) && (r != MCR_REG_RSV4) && !r[3];
  endfunction : wr_valid

  logic ours;
  logic trap;
  logic acc;
  logic wr;
  assign ours = req_i.valid && (req_i.coproc == MCR_COPROC_NUM);
  assign trap = ours && (!req_i.privileged || req_i.regnum[3]);
  assign acc = ours && !trap && (req_i.is_read ? rd_valid(req_i.regnum) : wr_valid(req_i.regnum));
  assign wr = acc && !req_i.is_read;

  // ----------------------------------------------------------------
  // Control register and table registers
  // ----------------------------------------------------------------
  logic ld_ctrl;
  logic ld_ttb;
  logic ld_dac;
  logic [MCR_CTRL_W-1:0] ctrl_q;
  assign ld_ctrl = wr && (req_i.regnum == MCR_REG_CTRL);
  assign ld_ttb = wr && (req_i.regnum == MCR_REG_TTB);
  assign ld_dac = wr && (req_i.regnum == MCR_REG_DAC);

  // Upper bits never stored, so they are zero by construction
  mcr_word_reg #(.WIDTH(MCR_CTRL_W), .RST(MCR_CTRL_RST)) u_ctrl (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .load_i(ld_ctrl),
    .data_i(req_i.wdata[MCR_CTRL_W-1:0]),
    .q_o(ctrl_q)
  );
  mcr_word_reg #(.WIDTH(32), .RST(MCR_WORD_RST)) u_ttb (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .load_i(ld_ttb),
    .data_i(req_i.wdata),
    .q_o(ttb_o)
  );
  mcr_word_reg #(.WIDTH(32), .RST(MCR_WORD_RST)) u_dac (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_r),
    .load_i(ld_dac),
    .data_i(req_i.wdata),
    .q_o(dac_o)
  );

  always_comb begin
    cfg_o.mmu_en = ctrl_q[MCR_BIT_MMU];
    cfg_o.align_en = ctrl_q[MCR_BIT_ALIGN];
    cfg_o.cache_en = ctrl_q[MCR_BIT_CACHE];
    cfg_o.wbuf_en = ctrl_q[MCR_BIT_WBUF];
    cfg_o.prog32 = ctrl_q[MCR_BIT_PROG32];
    cfg_o.data32 = ctrl_q[MCR_BIT_DATA32];
  end

  // ----------------------------------------------------------------
  // Response, read data and one-cycle maintenance strobes
  // ----------------------------------------------------------------
  mcr_resp_t resp_r;
  mcr_resp_t resp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [2:0] strb_r;
  logic [2:0] strb_nxt;
  logic [31:0] paddr_r;
  logic [31:0] paddr_nxt;

  always_comb begin
    resp_nxt = MCR_RESP_NONE;
    rdata_nxt = rdata_r;
    strb_nxt = 3'h0;
    paddr_nxt = paddr_r;
    if (trap) begin
      resp_nxt = MCR_RESP_UND;
    end else if (acc) begin
      resp_nxt = MCR_RESP_OK;
      if (req_i.is_read) begin
        case (req_i.regnum)
          MCR_REG_ID: rdata_nxt = ID_VALUE;
          MCR_REG_FSR: rdata_nxt = fault_status_i;
          MCR_REG_FAR: rdata_nxt = fault_addr_i;
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end else begin
        case (req_i.regnum)
          MCR_REG_FSR: strb_nxt = 3'h1;
          MCR_REG_FAR: begin
            strb_nxt = 3'h2;
            paddr_nxt = req_i.wdata;
          end
          MCR_REG_CFLUSH: strb_nxt = 3'h4;
          default: strb_nxt = 3'h0;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      resp_r <= MCR_RESP_NONE;
      rdata_r <= MCR_WORD_RST;
      strb_r <= 3'h0;
      paddr_r <= MCR_WORD_RST;
    end else begin
      resp_r <= resp_nxt;
      rdata_r <= rdata_nxt;
      strb_r <= strb_nxt;
      paddr_r <= paddr_nxt;
    end
  end

  always_comb begin
    case (resp_r)
      MCR_RESP_OK: begin
        done_o = 1'b1;
        und_trap_o = 1'b0;
      end
      MCR_RESP_UND: begin
        done_o = 1'b0;
        und_trap_o = 1'b1;
      end
      default: begin
        done_o = 1'b0;
        und_trap_o = 1'b0;
      end
    endcase
  end

  assign rdata_o = rdata_r;
  assign tlb_flush_o = strb_r[0];
  assign tlb_purge_o = strb_r[1];
  assign cache_flush_o = strb_r[2];
  assign purge_addr_o = paddr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_r);

  chk_user_traps: assert property (
    (req_i.valid && req_i.coproc == MCR_COPROC_NUM && !req_i.privileged) |=> und_trap_o && !done_o)
    else $error("user mode access did not trap");
  chk_high_traps: assert property (
    (req_i.valid && req_i.coproc == MCR_COPROC_NUM && req_i.regnum[3]) |=> und_trap_o)
    else $error("register 8-15 access did not trap");
  chk_invalid_silent: assert property (
    (ours && req_i.privileged && !req_i.regnum[3] && req_i.is_read && req_i.regnum == MCR_REG_CTRL)
    |=> !und_trap_o && !done_o)
    else $error("invalid register access answered");
  chk_other_cp: assert property (
    (req_i.valid && req_i.coproc != MCR_COPROC_NUM) |=> !done_o && !und_trap_o)
    else $error("foreign coprocessor access answered");
  chk_id_read: assert property (
    (acc && req_i.is_read && req_i.regnum == MCR_REG_ID) |=> rdata_o == ID_VALUE)
    else $error("identity read wrong");
  chk_ctrl_load: assert property (
    ld_ctrl |=> ctrl_q == $past(req_i.wdata[MCR_CTRL_W-1:0]))
    else $error("control write not stored");
  chk_ttb_hold: assert property (
    !ld_ttb |=> $stable(ttb_o))
    else $error("table base changed without write");
  chk_flush_pulse: assert property (
    (wr && req_i.regnum == MCR_REG_CFLUSH)
    |=> cache_flush_o ##1 (!cache_flush_o || $past(wr && req_i.regnum == MCR_REG_CFLUSH)))
    else $error("cache flush strobe wrong");
  // A trapped access must leave every stored word untouched
  chk_trap_no_effect: assert property (
    trap |=> $stable(ctrl_q) && $stable(ttb_o) && $stable(dac_o))
    else $error("trapped access changed a register");
  chk_mmu_bit: assert property (
    ld_ctrl |=> cfg_o.mmu_en == $past(req_i.wdata[MCR_BIT_MMU]))
    else $error("mmu enable mismatch");

  cov_ctrl_write: cover property (ld_ctrl);
  cov_trap: cover property (und_trap_o);
  cov_fsr_read: cover property (acc && req_i.is_read && req_i.regnum == MCR_REG_FSR);
  cov_purge: cover property (tlb_purge_o);
  cov_cache_flush: cover property (cache_flush_o);
endmodule : mcr_regbank
`default_nettype wire

// *** verilog/mcr_word_reg.sv ***
// File: one write-only word register with load strobe
`timescale 1ns/1ps
`default_nettype none
module mcr_word_reg #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] data_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  always_comb begin
    q_nxt = load_i ? data_i : q_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule : mcr_word_reg
`default_nettype wire
